// ==== pkg/light_alert_pkg.sv ====
// Constants for the light threshold alert logic
// Function
// RL1 - Compare only the selected channel
// RL2 - Alert pin is open drain
// RL3 - Polarity applies to faults and pulses
// RL4 - Latch field picks hysteresis or window
// RL5 - Transparent pin follows hysteresis thresholds
// RL6 - Transparent flags follow last out-of-window side
// RL7 - Latched pin holds until status read
// RL8 - Latched flags hold until status read
// RL9 - Persistence needs consecutive faults before change
// RL10 - Function zero drives threshold fault logic
// RL11 - Function one pulses each conversion
// RL12 - Function three pulses every four conversions
// RL13 - Flags keep updating in pulse functions
// RL14 - Channels convert in round robin
// RL15 - Inside window resets persistence, reserved functions
package light_alert_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register offsets
  localparam logic [7:0] OFS_THRESH_LOW = 8'h08;
  localparam logic [7:0] OFS_THRESH_HIGH = 8'h09;
  localparam logic [7:0] OFS_CONFIG = 8'h0a;
  localparam logic [7:0] OFS_STATE = 8'h0b;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  // Config field positions
  localparam int CFG_FAULT_LSB = 0;
  localparam int CFG_CHSEL_LSB = 2;
  localparam int CFG_LATCH_BIT = 4;
  localparam int CFG_POL_BIT = 5;
  localparam int CFG_FUNC_LSB = 6;
  localparam int CFG_W = 8;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Flag bit positions
  localparam int FLAG_LOW_BIT = 0;
  localparam int FLAG_HIGH_BIT = 1;
  // Alert function encodings
  localparam logic [1:0] FUNC_FAULT = 2'h0;
  localparam logic [1:0] FUNC_EACH_CONV = 2'h1;
  localparam logic [1:0] FUNC_ALL_CONV = 2'h3;
  localparam logic [1:0] LAST_CHANNEL = 2'h3;
  // Pulse timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC_INT = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] PULSE_CYC = 6'(PULSE_CYC_INT < 1 ? 1 : PULSE_CYC_INT);
  // Fault side of a measurement
  typedef enum logic [1:0] {SIDE_NONE, SIDE_HIGH, SIDE_LOW} side_type;
endpackage

// ==== design/light_threshold_alert_logic.sv ====
// Threshold comparison, persistence and alert pin control
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module light_threshold_alert_logic import light_alert_pkg::*; #(
  parameter int RES_W = 28,
  parameter int CNT_W = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  output logic [1:0] conv_channel,
  output logic alert_o,
  output logic alert_oe
);

  // Needed consecutive faults: 1, 2, 4 or 8
  function automatic logic [CNT_W-1:0] fault_need(input logic [1:0] code);
    fault_need = CNT_W'(1) << code;
  endfunction

  logic [RES_W-1:0] thresh_low_q, thresh_low_d;
  logic [RES_W-1:0] thresh_high_q, thresh_high_d;
  logic [CFG_W-1:0] config_q, config_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic flag_high_q, flag_high_d;
  logic flag_low_q, flag_low_d;
  logic fault_alert_q, fault_alert_d;
  logic [CNT_W-1:0] fault_cnt_q, fault_cnt_d;
  side_type last_side_q, last_side_d;
  logic [1:0] conv_ch_q, conv_ch_d;
  logic [5:0] pulse_cnt_q, pulse_cnt_d;
  logic alert_oe_q, alert_oe_d;
  logic alert_o_q;

  logic [1:0] fault_code;
  logic [1:0] ch_sel;
  logic latch_mode;
  logic alert_polarity;
  logic [1:0] alert_function;
  logic sel_conv;
  side_type side;
  logic trig_high;
  logic trig_low;
  logic flags_clear;
  logic alert_active;

  assign fault_code = config_q[CFG_FAULT_LSB +: 2];
  assign ch_sel = config_q[CFG_CHSEL_LSB +: 2];
  assign latch_mode = config_q[CFG_LATCH_BIT];
  assign alert_polarity = config_q[CFG_POL_BIT];
  assign alert_function = config_q[CFG_FUNC_LSB +: 2];

  // Register writes
  always_comb begin
    thresh_low_d = thresh_low_q;
    thresh_high_d = thresh_high_q;
    config_d = config_q;
    if (reg_wr) begin
      case (reg_addr)
        OFS_THRESH_LOW: thresh_low_d = reg_wdata[RES_W-1:0];
        OFS_THRESH_HIGH: thresh_high_d = reg_wdata[RES_W-1:0];
        OFS_CONFIG: config_d = reg_wdata[CFG_W-1:0];
        default: config_d = config_q;
      endcase
    end
  end

  // Read data, one cycle after the strobe, zero elsewhere
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_THRESH_LOW: rdata_d = DATA_W'(thresh_low_q);
        OFS_THRESH_HIGH: rdata_d = DATA_W'(thresh_high_q);
        OFS_CONFIG: rdata_d = DATA_W'(config_q);
        OFS_STATE: rdata_d = DATA_W'({fault_alert_q, conv_ch_q, fault_cnt_q});
        OFS_FLAGS: rdata_d = DATA_W'({flag_high_q, flag_low_q});
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      thresh_low_q <= '0;
      thresh_high_q <= '1;
      config_q <= CONFIG_RESET;
      rdata_q <= '0;
    end else begin
      thresh_low_q <= thresh_low_d;
      thresh_high_q <= thresh_high_d;
      config_q <= config_d;
      rdata_q <= rdata_d;
    end
  end

  // RL14 round robin channel
  always_comb begin
    conv_ch_d = conv_done ? conv_ch_q + 2'h1 : conv_ch_q;
  end

  // RL1 only the selected channel counts
  assign sel_conv = conv_done && (conv_ch_q == ch_sel);

  // Classify the measurement against the window
  always_comb begin
    side = SIDE_NONE;
    if (conv_result > thresh_high_q) begin
      side = SIDE_HIGH;
    end else if (conv_result < thresh_low_q) begin
      side = SIDE_LOW;
    end
  end

  // RL9 RL15 consecutive fault persistence
  always_comb begin
    fault_cnt_d = fault_cnt_q;
    last_side_d = last_side_q;
    trig_high = 1'b0;
    trig_low = 1'b0;
    if (sel_conv) begin
      last_side_d = side;
      if (side == SIDE_NONE) begin
        fault_cnt_d = '0;
      end else begin
        if (side != last_side_q) begin
          fault_cnt_d = CNT_W'(1);
        end else if (fault_cnt_q < fault_need(fault_code)) begin
          fault_cnt_d = fault_cnt_q + CNT_W'(1);
        end
        trig_high = (side == SIDE_HIGH) && (fault_cnt_d >= fault_need(fault_code));
        trig_low = (side == SIDE_LOW) && (fault_cnt_d >= fault_need(fault_code));
      end
    end
  end

  // Status read clears latched state
  assign flags_clear = reg_rd && (reg_addr == OFS_FLAGS) && latch_mode;

  // RL4 RL13 flags and fault alert per mode, independent of function
  always_comb begin
    flag_high_d = flag_high_q;
    flag_low_d = flag_low_q;
    fault_alert_d = fault_alert_q;
    if (latch_mode) begin
      // RL7 RL8 latched window, set wins over clear
      if (flags_clear) begin
        flag_high_d = 1'b0;
        flag_low_d = 1'b0;
        fault_alert_d = 1'b0;
      end
      if (trig_high) begin
        flag_high_d = 1'b1;
        fault_alert_d = 1'b1;
      end
      if (trig_low) begin
        flag_low_d = 1'b1;
        fault_alert_d = 1'b1;
      end
    end else begin
      // RL5 RL6 transparent hysteresis
      if (trig_high) begin
        flag_high_d = 1'b1;
        flag_low_d = 1'b0;
        fault_alert_d = 1'b1;
      end else if (trig_low) begin
        flag_high_d = 1'b0;
        flag_low_d = 1'b1;
        fault_alert_d = 1'b0;
      end
    end
  end

  // RL11 RL12 conversion complete pulse
  always_comb begin
    pulse_cnt_d = (pulse_cnt_q != '0) ? pulse_cnt_q - 6'h1 : pulse_cnt_q;
    if (conv_done && (alert_function == FUNC_EACH_CONV)) begin
      pulse_cnt_d = PULSE_CYC;
    end else if (conv_done && (alert_function == FUNC_ALL_CONV)
                 && (conv_ch_q == LAST_CHANNEL)) begin
      pulse_cnt_d = PULSE_CYC;
    end
  end

  // RL10 RL15 pin source by function, reserved stays inactive
  always_comb begin
    case (alert_function)
      FUNC_FAULT: alert_active = fault_alert_d;
      FUNC_EACH_CONV: alert_active = (pulse_cnt_d != '0);
      FUNC_ALL_CONV: alert_active = (pulse_cnt_d != '0);
      default: alert_active = 1'b0;
    endcase
    // RL2 RL3 pull low when the pin level must be low
    alert_oe_d = alert_polarity ? !alert_active : alert_active;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_high_q <= 1'b0;
      flag_low_q <= 1'b0;
      fault_alert_q <= 1'b0;
      fault_cnt_q <= '0;
      last_side_q <= SIDE_NONE;
      conv_ch_q <= 2'h0;
      pulse_cnt_q <= '0;
      alert_oe_q <= 1'b1;
      alert_o_q <= 1'b0;
    end else begin
      flag_high_q <= flag_high_d;
      flag_low_q <= flag_low_d;
      fault_alert_q <= fault_alert_d;
      fault_cnt_q <= fault_cnt_d;
      last_side_q <= last_side_d;
      conv_ch_q <= conv_ch_d;
      pulse_cnt_q <= pulse_cnt_d;
      alert_oe_q <= alert_oe_d;
      alert_o_q <= 1'b0;
    end
  end

  // Outputs from flops
  assign reg_rdata = rdata_q;
  assign conv_channel = conv_ch_q;
  assign alert_o = alert_o_q;
  assign alert_oe = alert_oe_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_sel_high;
    sel_conv && (side == SIDE_HIGH) && trig_high;
  endsequence

  sequence s_read_flags;
    flags_clear && !trig_high && !trig_low;
  endsequence

  a_channel_filter: assert property ( // RL1
    (conv_done && (conv_ch_q != ch_sel) && !flags_clear)
      |=> $stable(flag_high_q) && $stable(flag_low_q) && $stable(fault_cnt_q))
    else $error("Flags moved on an unselected channel");
  a_open_drain: assert property ( // RL2
    alert_o == 1'b0)
    else $error("Alert pin driven high");
  a_pulse_level: assert property ( // RL3
    (pulse_cnt_q > 6'h1 && alert_function == FUNC_EACH_CONV && $stable(config_q))
      |-> alert_oe == !alert_polarity)
    else $error("Pulse level ignores polarity");
  a_trans_high: assert property ( // RL6
    (!latch_mode and s_sel_high) |=> flag_high_q && !flag_low_q && fault_alert_q)
    else $error("Transparent high fault not reported");
  a_latch_hold: assert property ( // RL8
    (latch_mode && flag_high_q && !flags_clear && $stable(config_q)) |=> flag_high_q)
    else $error("Latched flag dropped without read");
  a_latch_clear: assert property ( // RL7
    (s_read_flags) |=> !flag_high_q && !flag_low_q && !fault_alert_q)
    else $error("Status read did not clear latch");
  a_persist_gate: assert property ( // RL9
    (trig_high || trig_low) |-> (fault_need(fault_code) == CNT_W'(1))
      || ((last_side_q == side) && (fault_cnt_q >= fault_need(fault_code) - CNT_W'(1))))
    else $error("Fault reported before persistence reached");
  a_pulse_width: assert property ( // RL11
    (conv_done && alert_function == FUNC_EACH_CONV) |=> pulse_cnt_q == PULSE_CYC)
    else $error("Conversion pulse not started");
  a_all_conv: assert property ( // RL12
    (conv_done && alert_function == FUNC_ALL_CONV && conv_ch_q != LAST_CHANNEL
      && pulse_cnt_q == '0) |=> pulse_cnt_q == '0)
    else $error("All-channel pulse on a middle conversion");
  a_rotation: assert property ( // RL14
    conv_done |=> conv_ch_q == $past(conv_ch_q) + 2'h1)
    else $error("Channel rotation broken");
  a_window_reset: assert property ( // RL15
    (sel_conv && side == SIDE_NONE) |=> fault_cnt_q == '0)
    else $error("Persistence not reset inside window");

endmodule
`default_nettype wire

// ==== testbench/alert_line_model.sv ====
// Pulled-up alert line shared with the host
`timescale 1ns/10ps
`default_nettype none
module alert_line_model (
  input wire logic alert_o,
  input wire logic alert_oe,
  output wire logic pin
);
  // open drain line
  // Released line floats up to the pull-up level
  assign pin = alert_oe ? alert_o : 1'b1;
endmodule
`default_nettype wire

// ==== testbench/light_threshold_alert_logic_tb.sv ====
// Register-level test of the light threshold alert logic
`timescale 1ns/10ps
`default_nettype none
module light_threshold_alert_logic_tb import light_alert_pkg::*;;
  logic core_clk = 0;
  logic resetn = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [DATA_W-1:0] reg_rdata;
  logic conv_done = 0;
  logic [27:0] conv_result = '0;
  logic [1:0] conv_channel;
  logic alert_o, alert_oe;
  wire logic pin;
  int n_errors = 0;
  int comparisons = 0;
  int hi_n = 0;
  logic clr_hi = 0;
  light_threshold_alert_logic DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_result(conv_result), .conv_channel(conv_channel),
    .alert_o(alert_o), .alert_oe(alert_oe));
  alert_line_model line (.alert_o(alert_o), .alert_oe(alert_oe), .pin(pin));
  // Clock at 20 MHz
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Counts cycles in which the line is high; clr_hi restarts the count
  always @(posedge core_clk) begin
    if (clr_hi) hi_n <= 0;
    else if (pin === 1'b1) hi_n <= hi_n + 1;
  end
  // Restart the count once the new configuration has reached the pin
  task count_start;
    clr_hi <= 1'b1;
    @(posedge core_clk);
    clr_hi <= 1'b0;
  endtask
  task results;
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // One conversion per 30 cycles; channel 2 gets v, the others a high value
  task rounds(input int n, input logic [27:0] v);
    for (int r = 0; r < n; r++) begin
      for (int i = 0; i < 4; i++) begin
        chk(32'(conv_channel), i); // rotation order
        @(posedge core_clk);
        conv_done <= 1'b1;
        conv_result <= (i == 2) ? v : 28'h00003e8;
        @(posedge core_clk);
        conv_done <= 1'b0;
        repeat (28) @(posedge core_clk);
      end
    end
  endtask
  // Watchdog ends a hung run
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    results();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(pin, 1'b1); // polarity zero idles high
    rd(8'h20, 32'h0);
    wr(OFS_THRESH_LOW, 32'h64);
    wr(OFS_THRESH_HIGH, 32'hc8);
    rd(OFS_THRESH_LOW, 32'h64); // low limit readback
    rd(OFS_THRESH_HIGH, 32'hc8); // high limit readback
    // Transparent, need four, channel 2, active high
    wr(OFS_CONFIG, 32'h2a);
    rd(OFS_CONFIG, 32'h2a); // mode field readback
    rounds(3, 28'h12c);
    rd(OFS_STATE, 32'h3); // three faults counted
    rd(OFS_FLAGS, 32'h0); // three faults not enough
    rounds(1, 28'h096);
    rounds(1, 28'h12c);
    rd(OFS_FLAGS, 32'h0); // inside window restarts count
    rounds(3, 28'h12c);
    rd(OFS_FLAGS, 32'h2); // high side flagged
    chk(pin, 1'b1); // active above high
    rounds(1, 28'h096);
    rd(OFS_FLAGS, 32'h2); // held between limits
    chk(pin, 1'b1); // held between limits
    rounds(4, 28'h032);
    rd(OFS_FLAGS, 32'h1); // low side flagged
    chk(pin, 1'b0); // inactive below low
    // Latched, need one, active low
    wr(OFS_CONFIG, 32'h18);
    rd(OFS_FLAGS, 32'h1);
    rounds(1, 28'h12c);
    rounds(1, 28'h032);
    chk(pin, 1'b0); // latched active low
    rd(OFS_FLAGS, 32'h3); // both flags latched
    chk(pin, 1'b1); // read releases alert
    rd(OFS_FLAGS, 32'h0); // read clears flags
    // Pulse on each conversion
    wr(OFS_CONFIG, 32'h68);
    count_start();
    rounds(1, 28'h12c);
    chk(hi_n, 80); // four pulses of 20 cycles
    rd(OFS_FLAGS, 32'h2); // flags still updated
    // Pulse once per rotation
    wr(OFS_CONFIG, 32'he8);
    count_start();
    rounds(2, 28'h032);
    chk(hi_n, 40); // one pulse each rotation
    rd(OFS_FLAGS, 32'h1); // flags still updated
    // Reserved function keeps the line inactive
    wr(OFS_CONFIG, 32'ha8);
    count_start();
    rounds(1, 28'h12c);
    chk(hi_n, 0); // reserved function quiet
    results();
  end
endmodule
`default_nettype wire
